// ---- design/cgt_params.svh ----
// offsets, field positions, reset values and timing counts of the gpio unit
`ifndef CGT_PARAMS_SVH
`define CGT_PARAMS_SVH
`define CGT_ADDR_W         16
`define CGT_OFS_TRIG_CFG   16'h0830
`define CGT_OFS_STB_DIV    16'h1104
`define CGT_OFS_FUNC0      16'h1110
`define CGT_OFS_TIME0      16'h1114
`define CGT_OFS_FUNC1      16'h1120
`define CGT_OFS_TIME1      16'h1124
`define CGT_OFS_FUNC2      16'h1130
`define CGT_OFS_TIME2      16'h1134
`define CGT_EN_BIT         31
`define CGT_ARM_BIT        25
`define CGT_MODE_LSB       16
`define CGT_LEVEL_BIT      0
`define CGT_DELAY_LSB      16
`define CGT_DIV_W          8
`define CGT_MODE_INPUT     8'h00
`define CGT_MODE_OUTPUT    8'h01
`define CGT_MODE_TRIGGER   8'h02
`define CGT_MODE_STROBE    8'h03
`define CGT_TMODE_EDGE     8'h00
`define CGT_TMODE_WIDTH    8'h01
`define CGT_RST_TRIG_CFG   32'h80000000
`define CGT_RST_FUNC0      32'h80000000
`define CGT_RST_FUNC1      32'h80030000
`define CGT_RST_FUNC2      32'h80020000
`define CGT_RST_DIV        32'h00000000
`define CGT_CLK_KHZ        25000
`define CGT_TICK_KHZ       49152
`define CGT_SHUTTER_NS     1000
`define CGT_SHUTTER_TICKS  ((`CGT_SHUTTER_NS * `CGT_TICK_KHZ + 999999) / 1000000)
`define CGT_TICK_STEP      ((64'd49152 * 64'd65536) / 64'd`CGT_CLK_KHZ)
`define CGT_RESP_OKAY      2'h0
`define CGT_RESP_SLVERR    2'h2
`endif

// ---- design/cgt_pkg.sv ----
// types shared by the gpio trigger and strobe unit
package cgt_pkg;
	typedef logic [7:0] cgt_mode_t;
	typedef enum logic [1:0] {TMR_IDLE, TMR_DELAY, TMR_ACTIVE} cgt_tmr_state_t;
endpackage

// ---- design/cgt_strobe_if.sv ----
// carries one pin's strobe timing and firing between top and timer
`timescale 1ns/1ps
interface cgt_strobe_if;
	logic [15:0] delayTicks;
	logic [15:0] durTicks;
	logic        fire;
	logic        active;
	modport ctrl (output delayTicks, output durTicks, output fire, input active);
	modport tmr  (input delayTicks, input durTicks, input fire, output active);
endinterface

// ---- design/cgt_strobe_timer.sv ----
// strobe delay and duration timer counting 49.152 MHz ticks on the system clock
`timescale 1ns/1ps
`include "cgt_params.svh"
module cgt_strobe_timer
	import cgt_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   reset_n,
	cgt_strobe_if.tmr   stb
);
	// 16.16 fixed point tick step per system clock, rounded down
	localparam logic [39:0] TICK_STEP = 40'(`CGT_TICK_STEP);

	cgt_tmr_state_t state_reg;
	logic [39:0]    tickAcc_reg;
	logic [23:0]    elapsed;
	logic [23:0]    endTick;

	assign elapsed = tickAcc_reg[39:16];
	assign endTick = {8'h00, stb.delayTicks} + {8'h00, stb.durTicks};
	assign stb.active = (state_reg == TMR_ACTIVE);

	// fractional accumulator, avoids a clock faster than clk_sys
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tickAcc_reg <= 40'h0000000000;
		end else if (stb.fire) begin
			tickAcc_reg <= 40'h0000000000;
		end else if (state_reg != TMR_IDLE) begin
			tickAcc_reg <= tickAcc_reg + TICK_STEP;
		end
	end

	// delay phase then active phase, a new exposure restarts both
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= TMR_IDLE;
		end else if (stb.fire) begin
			state_reg <= TMR_DELAY;
		end else begin
			case (state_reg)
				TMR_IDLE: state_reg <= TMR_IDLE;
				TMR_DELAY: begin
					if (elapsed >= {8'h00, stb.delayTicks}) begin
						state_reg <= (stb.durTicks == 16'h0000) ? TMR_IDLE : TMR_ACTIVE;
					end
				end
				TMR_ACTIVE: begin
					if (elapsed >= endTick) begin
						state_reg <= TMR_IDLE;
					end
				end
				default: state_reg <= TMR_IDLE;
			endcase
		end
	end
endmodule // cgt_strobe_timer

// ---- design/cgt_gpio_trigger_strobe.sv ----
// gpio unit: trigger input, strobe output, static input and output, axi4-lite registers
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cgt_params.svh"

module cgt_gpio_trigger_strobe
	import cgt_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [2:0]  ioLineIn,
	output logic [2:0]       ioLineOut,
	output logic [2:0]       ioLineOeN,
	input  wire logic        exposureStart,
	output logic             triggerStart,
	output logic             triggerLevel,
	output logic             extTriggerOn
);
	logic [31:0] trigCfg_reg;
	logic [31:0] stbDiv_reg;
	logic [31:0] func_reg [3];
	logic [31:0] timing_reg [3];
	logic [15:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        haveAw_reg;
	logic        haveW_reg;
	logic [2:0]  pinMeta_reg;
	logic [2:0]  pinSync_reg;
	logic        trigLowPrev_reg;
	logic [7:0]  skipCnt_reg;
	logic        doWrite;
	logic        trigArmed;
	logic        trigLow;
	logic        stbFire;
	logic [2:0]  stbActive;
	logic        trigWidthMode;
	logic        trigOn0;
	logic        trigOn2;
	logic        wrTrigCfg;
	logic        wrStbDiv;
	logic        wrLine;
	logic        wrTiming;
	logic        wrMapped;
	logic [1:0]  wrIdx;
	logic [15:0] rdAddr;
	logic        rdMapped;
	logic [2:0]  pinOut_next;
	logic [2:0]  pinOeN_next;

	// one timer carrier per line, line 0 included so every line can strobe
	cgt_strobe_if stbIf [3] ();

	// byte-lane merge, used by every writable register
	function automatic logic [31:0] mergeStrb(input logic [31:0] oldVal,
	                                          input logic [31:0] newVal,
	                                          input logic [3:0]  strb);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newVal[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// effective mode of a pin; a cleared enable bit leaves it a plain input
	function automatic cgt_mode_t pinMode(input logic [31:0] fr);
		return fr[`CGT_EN_BIT] ? fr[`CGT_MODE_LSB +: 8] : `CGT_MODE_INPUT;
	endfunction

	// decoded index of a function or timing register, 3 when not one
	function automatic logic [1:0] lineOf(input logic [15:0] a);
		case (a)
			`CGT_OFS_FUNC0, `CGT_OFS_TIME0: return 2'd0;
			`CGT_OFS_FUNC1, `CGT_OFS_TIME1: return 2'd1;
			`CGT_OFS_FUNC2, `CGT_OFS_TIME2: return 2'd2;
			default:                        return 2'd3;
		endcase
	endfunction

	// register readback, live pin level replaces bit 0 of an input
	function automatic logic [31:0] readReg(input logic [15:0] a);
		logic [1:0]  ln;
		logic [31:0] fr;
		ln = lineOf(a);
		fr = 32'h00000000;
		if (ln != 2'd3) begin
			fr = func_reg[ln];
		end
		if (a == `CGT_OFS_TRIG_CFG) begin
			return trigCfg_reg;
		end else if (a == `CGT_OFS_STB_DIV) begin
			return stbDiv_reg;
		end else if (ln != 2'd3 && a[3:0] == 4'h4) begin
			return timing_reg[ln];
		end else if (ln != 2'd3) begin
			if (pinMode(fr) == `CGT_MODE_INPUT) begin
				fr[`CGT_LEVEL_BIT] = pinSync_reg[ln];
			end
			return fr;
		end
		return 32'h00000000;
	endfunction

	// address hits one of the decoded registers
	function automatic logic isMapped(input logic [15:0] a);
		return (a == `CGT_OFS_TRIG_CFG) || (a == `CGT_OFS_STB_DIV) || (lineOf(a) != 2'd3);
	endfunction

	assign doWrite = haveAw_reg && haveW_reg && !s_axi_bvalid;

	// write target decode, shared by the register processes
	assign wrIdx     = lineOf(awAddr_reg);
	assign wrTrigCfg = doWrite && (awAddr_reg == `CGT_OFS_TRIG_CFG);
	assign wrStbDiv  = doWrite && (awAddr_reg == `CGT_OFS_STB_DIV);
	assign wrLine    = doWrite && (wrIdx != 2'd3);
	assign wrTiming  = awAddr_reg[3:0] == 4'h4;
	assign wrMapped  = isMapped(awAddr_reg);

	// read address is word aligned; the low two bits never pick a byte
	assign rdAddr   = {s_axi_araddr[15:2], 2'b00};
	assign rdMapped = isMapped(rdAddr);

	// write channel: address and data taken in either order, one write in flight
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			haveAw_reg    <= 1'b0;
			haveW_reg     <= 1'b0;
			awAddr_reg    <= 16'h0000;
			wData_reg     <= 32'h00000000;
			wStrb_reg     <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CGT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_reg    <= {s_axi_awaddr[15:2], 2'b00};
				haveAw_reg    <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_reg    <= s_axi_wdata;
				wStrb_reg    <= s_axi_wstrb;
				haveW_reg    <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				haveAw_reg   <= 1'b0;
				haveW_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrMapped ? `CGT_RESP_OKAY : `CGT_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read channel: data one edge after the address is taken
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CGT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= readReg(rdAddr);
			s_axi_rresp   <= rdMapped ? `CGT_RESP_OKAY : `CGT_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// trigger configuration; reset leaves external triggering off
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trigCfg_reg <= `CGT_RST_TRIG_CFG;
		end else if (wrTrigCfg) begin
			trigCfg_reg <= mergeStrb(trigCfg_reg, wData_reg, wStrb_reg);
		end
	end

	// strobe divider; bits above the low byte are kept but unused
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stbDiv_reg <= `CGT_RST_DIV;
		end else if (wrStbDiv) begin
			stbDiv_reg <= mergeStrb(stbDiv_reg, wData_reg, wStrb_reg);
		end
	end

	// per-line function and timing registers; line 1 starts as a 1 us shutter pulse
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			func_reg[0]   <= `CGT_RST_FUNC0;
			func_reg[1]   <= `CGT_RST_FUNC1;
			func_reg[2]   <= `CGT_RST_FUNC2;
			timing_reg[0] <= 32'h00000000;
			timing_reg[1] <= 32'(`CGT_SHUTTER_TICKS);
			timing_reg[2] <= 32'h00000000;
		end else if (wrLine && wrTiming) begin
			timing_reg[wrIdx] <= mergeStrb(timing_reg[wrIdx], wData_reg, wStrb_reg);
		end else if (wrLine) begin
			func_reg[wrIdx] <= mergeStrb(func_reg[wrIdx], wData_reg, wStrb_reg);
		end
	end

	// two-stage synchroniser on the pins; only the second stage is read
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_reg <= 3'b111;
			pinSync_reg <= 3'b111;
		end else begin
			pinMeta_reg <= ioLineIn;
			pinSync_reg <= pinMeta_reg;
		end
	end

	// trigger source: line 2 by default, line 0 as well once given the trigger code
	assign trigOn0 = pinMode(func_reg[0]) == `CGT_MODE_TRIGGER;
	assign trigOn2 = pinMode(func_reg[2]) == `CGT_MODE_TRIGGER;
	assign trigLow = (trigOn2 && !pinSync_reg[2]) || (trigOn0 && !pinSync_reg[0]);
	assign trigArmed = trigCfg_reg[`CGT_EN_BIT] && trigCfg_reg[`CGT_ARM_BIT];
	assign trigWidthMode = trigCfg_reg[`CGT_MODE_LSB +: 8] == `CGT_TMODE_WIDTH;

	// falling edge starts one acquisition; prev resets to idle so reset gives no edge
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			trigLowPrev_reg <= 1'b0;
			triggerStart    <= 1'b0;
		end else begin
			trigLowPrev_reg <= trigLow;
			triggerStart    <= trigArmed && trigLow && !trigLowPrev_reg;
		end
	end

	// width mode passes the low time on as the integration window
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			triggerLevel <= 1'b0;
			extTriggerOn <= 1'b0;
		end else begin
			triggerLevel <= trigArmed && trigWidthMode && trigLow;
			extTriggerOn <= trigArmed;
		end
	end

	// divider skips exposures so a looped-back trigger has time to re-arm
	assign stbFire = exposureStart && (skipCnt_reg == 8'h00);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			skipCnt_reg <= 8'h00;
		end else if (exposureStart) begin
			skipCnt_reg <= (skipCnt_reg == 8'h00) ? stbDiv_reg[`CGT_DIV_W-1:0]
			                                      : skipCnt_reg - 8'h01;
		end
	end

	// one timer per line, fired at each exposure start the divider passes while that line is in strobe mode
	for (genvar g = 0; g < 3; g++) begin : gLine
		assign stbIf[g].delayTicks = timing_reg[g][`CGT_DELAY_LSB +: 16];
		assign stbIf[g].durTicks   = timing_reg[g][15:0];
		assign stbIf[g].fire       = stbFire && (pinMode(func_reg[g]) == `CGT_MODE_STROBE);
		assign stbActive[g]        = stbIf[g].active;
		cgt_strobe_timer uTimer (
			.clk_sys (clk_sys),
			.reset_n (reset_n),
			.stb     (stbIf[g])
		);
	end

	// next pin drive per line; output enable is low while driving
	always_comb begin
		pinOut_next = 3'b000;
		pinOeN_next = 3'b111;
		for (int i = 0; i < 3; i++) begin
			case (pinMode(func_reg[i]))
				`CGT_MODE_OUTPUT: begin
					pinOut_next[i] = func_reg[i][`CGT_LEVEL_BIT];
					pinOeN_next[i] = 1'b0;
				end
				`CGT_MODE_STROBE: begin
					pinOut_next[i] = stbActive[i];
					pinOeN_next[i] = 1'b0;
				end
				default: begin
					pinOut_next[i] = 1'b0;
					pinOeN_next[i] = 1'b1;
				end
			endcase
		end
	end

	// one process owns all pins, so they change together and glitch free
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ioLineOut <= 3'b000;
			ioLineOeN <= 3'b111;
		end else begin
			ioLineOut <= pinOut_next;
			ioLineOeN <= pinOeN_next;
		end
	end
endmodule // cgt_gpio_trigger_strobe

// ---- test/cgt_gpio_sva.sv ----
// bus handshake and trigger checks on the gpio unit's top ports
`timescale 1ns/1ps
module cgt_gpio_sva (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        triggerStart,
	input wire logic        triggerLevel,
	input wire logic        extTriggerOn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// address and data taken together, the usual case
	sequence sWrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sRdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_wr_answer: assert property (sWrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (sRdTaken |=> s_axi_rvalid)
		else $error("read response late");
	chk_wr_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	chk_rd_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response not retired");
	chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	chk_trig_single: assert property (triggerStart |=> !triggerStart)
		else $error("trigger pulse longer than one cycle");
	chk_trig_armed: assert property (triggerStart |-> extTriggerOn || $past(extTriggerOn))
		else $error("trigger while disarmed");
	chk_level_armed: assert property (triggerLevel |-> extTriggerOn || $past(extTriggerOn))
		else $error("width trigger while disarmed");
endmodule // cgt_gpio_sva

bind cgt_gpio_trigger_strobe cgt_gpio_sva uChk (.clk_sys(clk_sys), .reset_n(reset_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.triggerStart(triggerStart), .triggerLevel(triggerLevel), .extTriggerOn(extTriggerOn));

// ---- test/cgt_pin_partner.sv ----
// external pin model: trigger source, loop wiring and released-line behaviour
`timescale 1ns/1ps
module cgt_pin_partner (
	input  wire logic       clk_sys,
	input  wire logic [2:0] ioLineOut,
	input  wire logic [2:0] ioLineOeN,
	input  wire logic [2:0] extLevel,
	input  wire logic       loop10,
	output logic [2:0]      ioLineIn
);
	logic flip = 1'b0;
	logic wire1;
	// line 1 has no pull, so a released line shows a moving level, not a held one
	always @(posedge clk_sys) begin
		flip <= ~flip;
	end
	assign wire1 = ioLineOeN[1] ? flip : ioLineOut[1];
	assign ioLineIn[1] = wire1;
	// line 0 follows line 1 when looped for free running
	assign ioLineIn[0] = !ioLineOeN[0] ? ioLineOut[0] : (loop10 ? wire1 : extLevel[0]);
	// line 2 idles high through its pull-up unless the source pulls it low
	assign ioLineIn[2] = !ioLineOeN[2] ? ioLineOut[2] : extLevel[2];
endmodule // cgt_pin_partner

// ---- test/tb_camera_gpio_trigger_strobe.sv ----
// self-checking bench for the gpio trigger and strobe unit
`timescale 1ns/1ps
module tb_camera_gpio_trigger_strobe;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, exposureStart = 0, loop10 = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  ioLineIn, ioLineOut, ioLineOeN;
	logic [2:0]  extLevel = 3'b100;
	logic        triggerStart, triggerLevel, extTriggerOn, lastOut = 0;
	int          cyc = 0, tExp = 0, tRise = 0, tFall = 0, rises = 0, trigCount = 0, r0;
	int          numErrors = 0, checkCount = 0;
	logic [15:0] regAddr [8] = '{16'h0830, 16'h1104, 16'h1110, 16'h1114, 16'h1120, 16'h1124,
		16'h1130, 16'h1134};
	logic [31:0] regRst [8] = '{32'h80000000, 32'h0, 32'h80000000, 32'h0, 32'h80030000,
		32'h00000032, 32'h80020000, 32'h0};

	cgt_gpio_trigger_strobe uut (.*);
	cgt_pin_partner uPins (.clk_sys(clk_sys), .ioLineOut(ioLineOut), .ioLineOeN(ioLineOeN),
		.extLevel(extLevel), .loop10(loop10), .ioLineIn(ioLineIn));

	always #20 clk_sys = ~clk_sys;

	// exposure and line 1 edge times, plus trigger pulse count
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		lastOut <= ioLineOut[1];
		if (exposureStart) tExp <= cyc;
		if (triggerStart === 1'b1) trigCount <= trigCount + 1;
		if (ioLineOut[1] === 1'b1 && !lastOut) begin
			rises <= rises + 1;
			tRise <= cyc;
		end
		if (ioLineOut[1] === 1'b0 && lastOut) tFall <= cyc;
	end

	task automatic endSim();
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// timer edges land on whole clocks, so allow a few cycles of slack
	task automatic chkNear(input int got, input real exp, input real tol);
		checkCount++;
		if (got < exp - tol || got > exp + tol) begin
			numErrors++;
			$display("mismatch at %0t got %h exp %h", $time, got, $rtoi(exp));
		end
	endtask
	task automatic waitCyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// write: offer address and data together, drop each once taken, then take the response
	task automatic axiWrite(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
		waitCyc(2);
	endtask
	task automatic axiRead(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
	endtask
	task automatic expose();
		exposureStart <= 1'b1;
		@(posedge clk_sys);
		exposureStart <= 1'b0;
	endtask
	task automatic pulse(input int n);
		extLevel[n] <= 1'b0;
		waitCyc(6);
		extLevel[n] <= 1'b1;
		waitCyc(6);
	endtask

	initial begin
		waitCyc(4);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) axiRead(regAddr[i], regRst[i], 2'h0);
		axiRead(16'h0004, 32'h0, 2'h2);
		axiWrite(16'h2000, 32'h1, 2'h2);
		chk(ioLineOeN[1], 1'b0);
		expose();
		waitCyc(60);
		chkNear(tFall - tRise, 25.0, 2);
		chkNear(tRise - tExp, 0.0, 4);
		$display("test defaults done");
		axiWrite(16'h0830, 32'h82000000, 2'h0);
		chk(extTriggerOn, 1'b1);
		pulse(2);
		pulse(0);
		chk(trigCount, 1);
		axiWrite(16'h1110, 32'h80020000, 2'h0);
		pulse(0);
		chk(trigCount, 2);
		axiWrite(16'h0830, 32'h02000000, 2'h0);
		chk(extTriggerOn, 1'b0);
		axiWrite(16'h0830, 32'h82000000, 2'h0);
		axiWrite(16'h0830, 32'h80000000, 2'h0);
		pulse(2);
		chk({extTriggerOn, trigCount[30:0]}, 2);
		axiWrite(16'h0830, 32'h82010000, 2'h0);
		extLevel[2] <= 1'b0;
		waitCyc(6);
		chk(triggerLevel, 1'b1);
		extLevel[2] <= 1'b1;
		waitCyc(6);
		chk(triggerLevel, 1'b0);
		axiWrite(16'h0830, 32'h80000000, 2'h0);
		$display("test trigger done");
		axiWrite(16'h1110, 32'h80000000, 2'h0);
		extLevel[0] <= 1'b1;
		waitCyc(4);
		axiRead(16'h1110, 32'h80000001, 2'h0);
		extLevel[0] <= 1'b0;
		waitCyc(4);
		axiRead(16'h1110, 32'h80000000, 2'h0);
		axiWrite(16'h1120, 32'h80010001, 2'h0);
		chk({ioLineOeN[1], ioLineOut[1]}, 2'b01);
		axiWrite(16'h1120, 32'h80010000, 2'h0);
		chk({ioLineOeN[1], ioLineOut[1]}, 2'b00);
		axiWrite(16'h1120, 32'h00010001, 2'h0);
		chk(ioLineOeN[1], 1'b1);
		axiWrite(16'h1110, 32'h80010001, 2'h0);
		chk({ioLineOeN[0], ioLineOut[0]}, 2'b01);
		$display("test static pins done");
		axiWrite(16'h1120, 32'h80030000, 2'h0);
		axiWrite(16'h1124, 32'h000904D3, 2'h0);
		r0 = rises;
		repeat (3) begin
			expose();
			waitCyc(800);
		end
		chk(rises - r0, 3);
		chkNear(tFall - tRise, 1235 * 25.0 / 49.152, 2);
		chkNear(tRise - tExp, 9 * 25.0 / 49.152, 4);
		expose();
		waitCyc(300);
		expose();
		waitCyc(800);
		chkNear(tFall - tExp, 1244 * 25.0 / 49.152, 4);
		axiWrite(16'h1104, 32'h00000001, 2'h0);
		r0 = rises;
		repeat (4) begin
			expose();
			waitCyc(700);
		end
		chk(rises - r0, 2);
		axiWrite(16'h1104, 32'h00000000, 2'h0);
		axiWrite(16'h1124, 32'h1333C000, 2'h0);
		expose();
		waitCyc(28000);
		chkNear(tRise - tExp, 4915 * 25.0 / 49.152, 5);
		chkNear(tFall - tRise, 25000.0, 2);
		$display("test strobe done");
		axiWrite(16'h1124, 32'h00090010, 2'h0);
		axiWrite(16'h1134, 32'h000904D3, 2'h0);
		axiWrite(16'h1130, 32'h80030000, 2'h0);
		expose();
		waitCyc(300);
		chk({ioLineOeN[2], ioLineOut[2]}, 2'b01);
		waitCyc(500);
		chk({ioLineOeN[2], ioLineOut[2]}, 2'b00);
		axiWrite(16'h1130, 32'h80020000, 2'h0);
		axiWrite(16'h1110, 32'h80020000, 2'h0);
		loop10 <= 1'b1;
		axiWrite(16'h0830, 32'h82000000, 2'h0);
		r0 = trigCount;
		expose();
		waitCyc(40);
		chk(trigCount - r0, 1);
		$display("test free running done");
		endSim();
	end

	// cut a hang short, about twice the expected run
	initial begin
		#3000000;
		numErrors++;
		endSim();
	end
endmodule // tb_camera_gpio_trigger_strobe
